// ---- verilog/dacs_top.sv ----
// control, sampling pipeline and output drive of the dual converter
`timescale 1ns/1ps
module dacs_top
   import dacs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic input_clock,
   input wire logic serial_cs_n,
   input wire logic serial_clock,
   input wire logic serial_data,
   input wire logic output_enable_n,
   input wire logic power_down_input,
   input wire logic internal_reference_off,
   input wire logic [WORD_W-1:0] core_code_a,
   input wire logic [WORD_W-1:0] core_code_b,
   output logic sample_take,
   output logic [WORD_W-1:0] primary_output_bus,
   output logic primary_output_bus_oe,
   output logic [WORD_W-1:0] secondary_output_bus,
   output logic secondary_output_bus_oe,
   output logic output_latch_clock,
   output logic output_latch_clock_n,
   output logic output_latch_clock_oe,
   output logic [GAIN_W-1:0] gain_code_a,
   output logic [GAIN_W-1:0] gain_code_b,
   output logic reference_enable,
   output logic converter_active
);
   logic [PIN_N-1:0] pins;
   logic [PIN_N-1:0] sync1;
   logic [PIN_N-1:0] sync2;
   logic clk_prev;
   logic clk_rise;
   logic pd;
   logic advance;
   dacs_ctrl_s ctrl;
   dacs_ctrl_s wr_word;
   logic wr_strobe;
   logic sample_every;
   logic phase;
   logic take_sample;
   logic isc;
   logic isc_q;
   logic isc_fall;
   logic [1:0] gain_cnt;
   logic [GAIN_W-1:0] pend_a;
   logic [GAIN_W-1:0] pend_b;
   dacs_smp_s pipe [PIPE_DEPTH];
   logic [3:0] lat_a;
   logic [3:0] lat_b;
   dacs_smp_s ent_a;
   dacs_smp_s ent_b;
   logic drive;

   // every pin crosses two flops; only sync2 is read by logic
   assign pins = {internal_reference_off, power_down_input, output_enable_n, serial_data,
                  serial_clock, serial_cs_n, input_clock};
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= 7'h12;
         sync2 <= 7'h12;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
      end
   end

   assign pd = sync2[PIN_PD];
   assign clk_rise = sync2[PIN_CLK] & ~clk_prev;
   assign advance = clk_rise & ~pd;
   assign converter_active = ~pd;
   assign reference_enable = ~sync2[PIN_REF_OFF];

   dacs_serial_rx u_serial (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .cs_n(sync2[PIN_CS_N]),
      .sclk(sync2[PIN_SCLK]),
      .sdi(sync2[PIN_SDI]),
      .word(wr_word),
      .strobe(wr_strobe)
   );

   // format, mode and bus bits act from the load onward
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= CTRL_RESET;
      end else if (wr_strobe) begin
         ctrl <= wr_word;
      end
   end

   // only mode 1 with dual bus runs the input clock at 40 MHz
   assign sample_every = ctrl.clock_mode & ~ctrl.bus_select;
   assign take_sample = advance & (sample_every | ~phase);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         clk_prev <= 1'b0;
         phase <= 1'b0;
         sample_take <= 1'b0;
      end else begin
         clk_prev <= sync2[PIN_CLK];
         sample_take <= take_sample;
         if (advance) begin
            phase <= sample_every ? 1'b0 : ~phase;
         end
      end
   end

   // internal sample clock is 40 MHz in all modes
   assign isc = sample_every ? sync2[PIN_CLK] : phase;
   assign isc_fall = isc_q & ~isc;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         isc_q <= 1'b0;
         output_latch_clock <= 1'b0;
         output_latch_clock_n <= 1'b1;
      end else begin
         isc_q <= isc;
         // latch clock follows the input clock in mode 1, the half-rate phase in mode 0
         output_latch_clock <= ctrl.clock_mode ? sync2[PIN_CLK] : phase;
         output_latch_clock_n <= ctrl.clock_mode ? ~sync2[PIN_CLK] : ~phase;
      end
   end

   // gain codes wait for two sample clock falls so the amplifiers never switch mid-sample
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         gain_cnt <= 2'h0;
         pend_a <= '0;
         pend_b <= '0;
         gain_code_a <= '0;
         gain_code_b <= '0;
      end else if (wr_strobe) begin
         pend_a <= wr_word.gain_code_a;
         pend_b <= wr_word.gain_code_b;
         gain_cnt <= GAIN_APPLY_FALLS;
      end else if (isc_fall && gain_cnt != 2'h0) begin
         gain_cnt <= gain_cnt - 2'h1;
         if (gain_cnt == 2'h1) begin
            gain_code_a <= pend_a;
            gain_code_b <= pend_b;
         end
      end
   end

   // pipeline advances once per input clock rise; stage k holds the word taken k rises ago
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pipe[0] <= '0;
      end else if (advance) begin
         pipe[0] <= '{valid: take_sample, a: core_code_a, b: core_code_b};
      end
   end

   genvar gi;
   generate
      for (gi = 1; gi < PIPE_DEPTH; gi++) begin : g_stage
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               pipe[gi] <= '0;
            end else if (advance) begin
               pipe[gi] <= pipe[gi-1];
            end
         end
      end
   endgenerate

   assign lat_a = ctrl.bus_select ? LAT_SGL_A : (ctrl.clock_mode ? LAT_DUAL_40 : LAT_DUAL_80);
   assign lat_b = ctrl.bus_select ? LAT_SGL_B : lat_a;
   assign ent_a = pipe[lat_a - 4'h1];
   assign ent_b = pipe[lat_b - 4'h1];

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         primary_output_bus <= '0;
         secondary_output_bus <= '0;
      end else if (advance) begin
         if (!ctrl.bus_select) begin
            if (ent_a.valid) begin
               primary_output_bus <= dacs_fmt(ent_a.a, ctrl.signed_output_select);
               secondary_output_bus <= dacs_fmt(ent_a.b, ctrl.signed_output_select);
            end
         end else if (ent_a.valid) begin
            primary_output_bus <= dacs_fmt(ent_a.a, ctrl.signed_output_select);
         end else if (ent_b.valid) begin
            primary_output_bus <= dacs_fmt(ent_b.b, ctrl.signed_output_select);
         end
      end
   end

   // the pad enables are gates of synchronised levels, hence a two-cycle pin-to-pad delay
   assign drive = ~sync2[PIN_OE_N] & ~pd;
   assign primary_output_bus_oe = drive;
   assign output_latch_clock_oe = drive;
   assign secondary_output_bus_oe = drive & ~ctrl.bus_select;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   logic [2:0] rises_since;
   logic seen_take;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rises_since <= 3'h0;
         seen_take <= 1'b0;
      end else if (wr_strobe) begin
         seen_take <= 1'b0;
      end else if (take_sample) begin
         rises_since <= 3'h0;
         seen_take <= 1'b1;
      end else if (advance && rises_since != 3'h7) begin
         rises_since <= rises_since + 3'h1;
      end
   end

   sequence dual80_word_s;
      advance && !ctrl.bus_select && !ctrl.clock_mode && pipe[7].valid;
   endsequence
   sequence dual40_word_s;
      advance && !ctrl.bus_select && ctrl.clock_mode && pipe[3].valid;
   endsequence
   sequence single_b_word_s;
      advance && ctrl.bus_select && pipe[8].valid && !pipe[7].valid;
   endsequence

   sample_alt_a: assert property (take_sample && !sample_every && seen_take |-> rises_since == 3'h1)
      else $error("80 MHz mode did not sample every second rise");
   lat_dual80_a: assert property (dual80_word_s |=>
      primary_output_bus == dacs_fmt($past(pipe[7].a), ctrl.signed_output_select))
      else $error("dual bus latency 8 word wrong");
   lat_dual40_a: assert property (dual40_word_s |=>
      secondary_output_bus == dacs_fmt($past(pipe[3].b), ctrl.signed_output_select))
      else $error("dual bus latency 4 word wrong");
   lat_single_b_a: assert property (single_b_word_s |=>
      primary_output_bus == dacs_fmt($past(pipe[8].b), ctrl.signed_output_select))
      else $error("single bus channel B latency 9 word wrong");
   hiz_on_oe_a: assert property ($rose(sync2[PIN_OE_N]) |-> !primary_output_bus_oe && !output_latch_clock_oe)
      else $error("outputs still driven after output enable rose");
   standby_hold_a: assert property (pd [*2] |-> !take_sample && $stable(pipe[0]))
      else $error("conversion ran during standby");
   ref_off_a: assert property ($rose(sync2[PIN_REF_OFF]) |-> !reference_enable)
      else $error("internal reference left on");
   ctrl_load_a: assert property (wr_strobe |=> ctrl == $past(wr_word))
      else $error("control word not loaded");
   gain_sync_a: assert property ($changed(gain_code_a) |-> $past(isc_fall) && $past(gain_cnt) == 2'h1)
      else $error("gain changed off the second sample clock fall");
   single_float_a: assert property (ctrl.bus_select |-> !secondary_output_bus_oe)
      else $error("secondary bus driven in single bus mode");
endmodule

// ---- verilog/dacs_pkg.sv ----
// constants, carriers and helpers shared by the dual converter control block
package dacs_pkg;
   localparam int WORD_W = 10;
   localparam int CTRL_W = 16;
   localparam int GAIN_W = 5;
   localparam int PIPE_DEPTH = 9;
   // pipeline latency in input clock cycles per output arrangement
   localparam logic [3:0] LAT_DUAL_80 = 4'h8;
   localparam logic [3:0] LAT_DUAL_40 = 4'h4;
   localparam logic [3:0] LAT_SGL_A = 4'h8;
   localparam logic [3:0] LAT_SGL_B = 4'h9;
   // falling edges of the internal sample clock before new gain codes apply
   localparam logic [1:0] GAIN_APPLY_FALLS = 2'h2;
   localparam logic [3:0] LAST_BIT = 4'hf;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
   // positions of the pins in the synchroniser vector
   localparam int PIN_N = 7;
   localparam int PIN_CLK = 0;
   localparam int PIN_CS_N = 1;
   localparam int PIN_SCLK = 2;
   localparam int PIN_SDI = 3;
   localparam int PIN_OE_N = 4;
   localparam int PIN_PD = 5;
   localparam int PIN_REF_OFF = 6;

   // control word, first serial bit lands in must_be_zero[2]
   typedef struct packed {
      logic [2:0] must_be_zero;
      logic bus_select;
      logic clock_mode;
      logic signed_output_select;
      logic [GAIN_W-1:0] gain_code_b;
      logic [GAIN_W-1:0] gain_code_a;
   } dacs_ctrl_s;

   typedef struct packed {
      logic valid;
      logic [WORD_W-1:0] a;
      logic [WORD_W-1:0] b;
   } dacs_smp_s;

   typedef enum logic [1:0] {
      SR_IDLE = 2'b00,
      SR_SHIFT = 2'b01,
      SR_ARMED = 2'b10,
      SR_DONE = 2'b11
   } dacs_ser_e;

   // offset binary in, msb flipped for two's complement
   function automatic logic [WORD_W-1:0] dacs_fmt(input logic [WORD_W-1:0] code, input logic tc);
      return {code[WORD_W-1] ^ tc, code[WORD_W-2:0]};
   endfunction
endpackage

// ---- verilog/dacs_serial_rx.sv ----
// write-only three-wire serial receiver for the control word
`timescale 1ns/1ps
module dacs_serial_rx
   import dacs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   output dacs_ctrl_s word,
   output logic strobe
);
   dacs_ser_e state;
   logic cs_prev;
   logic sclk_prev;
   logic sdi_prev;
   logic [3:0] cnt;
   logic [CTRL_W-1:0] shreg;
   logic sclk_fall;
   logic sclk_rise;
   logic cs_rise;
   logic cs_fall;

   assign sclk_fall = sclk_prev & ~sclk;
   assign sclk_rise = ~sclk_prev & sclk;
   assign cs_rise = ~cs_prev & cs_n;
   assign cs_fall = cs_prev & ~cs_n;

   // sdi is taken from the sample before the fall so its setup window is used, not its hold
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cs_prev <= 1'b1;
         sclk_prev <= 1'b0;
         sdi_prev <= 1'b0;
      end else begin
         cs_prev <= cs_n;
         sclk_prev <= sclk;
         sdi_prev <= sdi;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= SR_IDLE;
         cnt <= 4'h0;
         shreg <= CTRL_RESET;
         word <= CTRL_RESET;
         strobe <= 1'b0;
      end else begin
         strobe <= 1'b0;
         case (state)
            SR_IDLE: begin
               cnt <= 4'h0;
               if (cs_fall) begin
                  state <= SR_SHIFT;
               end
            end
            SR_SHIFT: begin
               if (cs_rise) begin
                  state <= SR_IDLE;
               end else if (sclk_fall) begin
                  shreg <= {shreg[CTRL_W-2:0], sdi_prev};
                  cnt <= cnt + 4'h1;
                  if (cnt == LAST_BIT) begin
                     state <= SR_ARMED;
                  end
               end
            end
            SR_ARMED: begin
               if (sclk_rise || cs_rise) begin
                  word <= shreg;
                  strobe <= 1'b1;
                  state <= cs_rise ? SR_IDLE : SR_DONE;
               end
            end
            SR_DONE: begin
               // extra clocks after a completed word are ignored until deselect
               if (cs_rise) begin
                  state <= SR_IDLE;
               end
            end
            default: state <= SR_IDLE;
         endcase
      end
   end

   short_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (state == SR_SHIFT && cs_rise) |=> !strobe [*2])
      else $error("short write loaded the control word");
endmodule

// ---- verif/dacs_host_model.sv ----
// host model: free-running converter clock and write-only serial control frames
`timescale 1ns/1ps
module dacs_host_model
   import dacs_pkg::*;
(
   input wire logic ref_clk,
   output logic input_clock,
   output logic serial_cs_n,
   output logic serial_clock,
   output logic serial_data
);
   // converter clock runs free; 64 ns period, moved on ref_clk falls
   initial begin
      input_clock = 1'b0;
      #4;
      forever #32 input_clock = ~input_clock;
   end

   initial begin
      serial_cs_n = 1'b1;
      serial_clock = 1'b0;
      serial_data = 1'b0;
   end

   task automatic hold8();
      repeat (8) @(negedge ref_clk);
   endtask

   // whole=0 stops after 15 falls so the frame must be dropped
   task automatic send(input logic [CTRL_W-1:0] w, input logic whole);
      @(negedge ref_clk);
      serial_cs_n = 1'b0;
      hold8();
      for (int i = 0; i < CTRL_W; i++) begin
         if (whole || i < CTRL_W - 1) begin
            serial_clock = 1'b1;
            serial_data = w[CTRL_W-1-i];
            hold8();
            serial_clock = 1'b0;
            hold8();
         end
      end
      if (whole) begin
         serial_clock = 1'b1;
         hold8();
      end
      serial_cs_n = 1'b1;
      serial_clock = 1'b0;
      // released line must not keep showing the last bit
      serial_data = ~serial_data;
      hold8();
   endtask
endmodule

// ---- verif/dacs_top_tb_top.sv ----
// self-checking bench for the dual converter control block
`timescale 1ns/1ps
module dacs_top_tb_top
   import dacs_pkg::*;
;
   localparam logic [WORD_W-1:0] NORM_A = 10'h0f0;
   localparam logic [WORD_W-1:0] NORM_B = 10'h00f;
   localparam logic [WORD_W-1:0] MARK_A = 10'h30c;
   localparam logic [WORD_W-1:0] MARK_B = 10'h2b3;
   localparam logic [GAIN_W-1:0] GA = 5'h13;
   localparam logic [GAIN_W-1:0] GB = 5'h0c;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic input_clock, serial_cs_n, serial_clock, serial_data;
   logic output_enable_n = 1'b0;
   logic power_down_input = 1'b0;
   logic internal_reference_off = 1'b0;
   logic [WORD_W-1:0] core_code_a = NORM_A;
   logic [WORD_W-1:0] core_code_b = NORM_B;
   logic sample_take, primary_output_bus_oe, secondary_output_bus_oe;
   logic output_latch_clock, output_latch_clock_n, output_latch_clock_oe;
   logic reference_enable, converter_active;
   logic [WORD_W-1:0] primary_output_bus, secondary_output_bus;
   logic [GAIN_W-1:0] gain_code_a, gain_code_b;
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;

   always #2 ref_clk = ~ref_clk;

   dacs_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .input_clock(input_clock), .serial_cs_n(serial_cs_n),
      .serial_clock(serial_clock), .serial_data(serial_data), .output_enable_n(output_enable_n),
      .power_down_input(power_down_input), .internal_reference_off(internal_reference_off),
      .core_code_a(core_code_a), .core_code_b(core_code_b), .sample_take(sample_take),
      .primary_output_bus(primary_output_bus), .primary_output_bus_oe(primary_output_bus_oe),
      .secondary_output_bus(secondary_output_bus), .secondary_output_bus_oe(secondary_output_bus_oe),
      .output_latch_clock(output_latch_clock), .output_latch_clock_n(output_latch_clock_n),
      .output_latch_clock_oe(output_latch_clock_oe), .gain_code_a(gain_code_a), .gain_code_b(gain_code_b),
      .reference_enable(reference_enable), .converter_active(converter_active));

   dacs_host_model host (.ref_clk(ref_clk), .input_clock(input_clock), .serial_cs_n(serial_cs_n),
      .serial_clock(serial_clock), .serial_data(serial_data));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // gains settle on internal clock falls, so wait a bounded time for them
   task automatic wait_gains(input logic [GAIN_W-1:0] ea, input logic [GAIN_W-1:0] eb);
      for (int i = 0; i < 100 && !(gain_code_a === ea && gain_code_b === eb); i++) @(negedge ref_clk);
   endtask

   // mark one sample, then count converter clock rises until each mark shows
   task automatic measure(input logic mode, input logic sel, input logic tc, input int la, input int lb);
      int r, ra, rb, n, lc;
      logic prev, lprev;
      logic [WORD_W-1:0] ea, eb;
      r = 0;
      ra = -1;
      rb = -1;
      n = 0;
      lc = 0;
      ea = {MARK_A[9] ^ tc, MARK_A[8:0]};
      eb = {MARK_B[9] ^ tc, MARK_B[8:0]};
      host.send({3'h0, sel, mode, tc, GB, GA}, 1'b1);
      @(posedge sample_take);
      @(negedge ref_clk);
      core_code_a = MARK_A;
      core_code_b = MARK_B;
      @(posedge sample_take);
      @(negedge ref_clk);
      core_code_a = NORM_A;
      core_code_b = NORM_B;
      prev = input_clock;
      lprev = output_latch_clock;
      for (int i = 0; i < 400 && r < 11; i++) begin
         // look just after the edge so registered outputs have settled
         @(posedge ref_clk);
         #1;
         if (input_clock && !prev) r++;
         prev = input_clock;
         if (r >= 1 && r <= 10 && output_latch_clock === 1'b1 && lprev === 1'b0) lc++;
         lprev = output_latch_clock;
         if (r >= 1 && r <= 10 && sample_take === 1'b1) n++;
         if (ra < 0 && primary_output_bus === ea) ra = r;
         if (rb < 0 && (sel ? primary_output_bus : secondary_output_bus) === eb) rb = r;
      end
      chk(ra, la);
      chk(rb, lb);
      chk(n, (mode && !sel) ? 10 : 5);
      chk(secondary_output_bus_oe, !sel);
      chk(lc, mode ? 10 : 5);
      chk(output_latch_clock ^ output_latch_clock_n, 1'b1);
      $display("test latency mode %0d select %0d done", mode, sel);
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end

   initial begin
      int n;
      repeat (3) @(negedge ref_clk);
      chk(gain_code_a, 5'h00);
      chk(primary_output_bus_oe, 1'b0);
      arst_n = 1'b1;
      repeat (6) @(negedge ref_clk);
      chk({gain_code_b, gain_code_a}, 10'h000);
      $display("test reset done");
      host.send({3'h0, 1'b0, 1'b1, 1'b0, GB, GA}, 1'b1);
      wait_gains(GA, GB);
      chk({gain_code_b, gain_code_a}, {GB, GA});
      host.send({3'h0, 1'b0, 1'b1, 1'b0, 5'h1f, 5'h01}, 1'b0);
      repeat (100) @(negedge ref_clk);
      chk({gain_code_b, gain_code_a}, {GB, GA});
      $display("test gain and short write done");
      measure(1'b0, 1'b0, 1'b0, 8, 8);
      measure(1'b1, 1'b0, 1'b1, 4, 4);
      measure(1'b0, 1'b1, 1'b1, 8, 9);
      measure(1'b1, 1'b1, 1'b0, 8, 9);
      output_enable_n = 1'b1;
      repeat (6) @(negedge ref_clk);
      chk({primary_output_bus_oe, output_latch_clock_oe}, 2'b00);
      output_enable_n = 1'b0;
      repeat (6) @(negedge ref_clk);
      chk({primary_output_bus_oe, output_latch_clock_oe}, 2'b11);
      $display("test output enable done");
      power_down_input = 1'b1;
      repeat (6) @(negedge ref_clk);
      chk({converter_active, primary_output_bus_oe}, 2'b00);
      n = 0;
      repeat (64) begin
         @(negedge ref_clk);
         if (sample_take !== 1'b0) n++;
      end
      chk(n, 0);
      @(negedge ref_clk);
      power_down_input = 1'b0;
      internal_reference_off = 1'b1;
      repeat (6) @(negedge ref_clk);
      chk({converter_active, reference_enable}, 2'b10);
      internal_reference_off = 1'b0;
      repeat (6) @(negedge ref_clk);
      chk(reference_enable, 1'b1);
      $display("test standby and reference done");
      end_of_test();
   end
endmodule
